// ### pbp_pkg.sv
// Package for the pattern buffer pointer port: constants and carriers
package pbp_pkg;

  localparam int          IDX_W          = 2;
  localparam int          SLV_ADDR_W     = 7;
  localparam logic [6:0]  SLV_ADDR_LOW   = 7'h1B;
  localparam logic [6:0]  SLV_ADDR_HIGH  = 7'h1D;
  localparam logic [1:0]  IDX_RESET      = 2'h0;
  localparam logic [1:0]  IDX_STEP       = 2'h1;
  localparam logic        OE_DRIVE       = 1'b0;
  localparam logic        OE_RELEASE     = 1'b1;

  // Pin drive bundle for one group of port pins
  typedef struct packed {
    logic [1:0] index;
    logic       swap;
  } pbp_pins_s;

  typedef enum logic [2:0] {
    PBP_STRAP   = 3'b001,
    PBP_PARKED  = 3'b010,
    PBP_ACTIVE  = 3'b100
  } pbp_state_e;

endpackage : pbp_pkg

// ### pbp_port.sv
// Pattern buffer pointer port with shared address strap pin
//
// What this block does
// - The shared strap pin is sampled when the flash load completes to choose one of two 7-bit addresses.
// - A low strap selects slave address 0x1B.
// - A high strap selects slave address 0x1D.
// - Two output pins carry the index of the one of four pattern buffers in use.
// - A swap output tells the external manager when to advance to the next buffer.
// - The shared pin is an input at reset release so the strap can be read first.
// - After the flash load the index and swap pins become outputs driven low, still inactive.
// - The pins stay inactive until the host sets the output enable control.
`timescale 1ns/10ps
module pbp_port (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 flash_loaded_i,
  input  wire logic                 out_enable_i,
  input  wire logic                 advance_i,
  input  wire logic                 buffer_index_bit1_i,
  output logic                      buffer_index_bit0_o,
  output logic                      buffer_index_bit1_o,
  output logic                      buffer_index_bit1_oe_b_o,
  output logic                      buffer_index_bit0_oe_b_o,
  output logic                      buffer_swap_o,
  output logic                      buffer_swap_oe_b_o,
  output logic [6:0]                slave_addr_o,
  output logic                      addr_valid_o
);

  // Strap pin synchroniser; first stage read only by second
  logic       strap_s1_ff;
  logic       strap_s2_ff;
  logic       nxt_strap_s1;
  logic       nxt_strap_s2;

  pbp_pkg::pbp_state_e state_ff;
  pbp_pkg::pbp_state_e nxt_state;
  pbp_pkg::pbp_pins_s  pins_ff;
  pbp_pkg::pbp_pins_s  nxt_pins;
  logic       oe_b_ff;
  logic       nxt_oe_b;
  logic       idx1_oe_b_ff;
  logic       nxt_idx1_oe_b;
  logic [6:0] addr_ff;
  logic [6:0] nxt_addr;
  logic       addr_valid_ff;
  logic       nxt_addr_valid;

  function automatic logic [6:0] pick_addr(input logic strap);
    pick_addr = strap ? pbp_pkg::SLV_ADDR_HIGH : pbp_pkg::SLV_ADDR_LOW;
  endfunction : pick_addr

  always_comb begin
    nxt_strap_s1 = buffer_index_bit1_i;
    nxt_strap_s2 = strap_s1_ff;
  end

  always_comb begin
    nxt_state      = state_ff;
    nxt_pins       = pins_ff;
    nxt_oe_b       = oe_b_ff;
    nxt_idx1_oe_b  = idx1_oe_b_ff;
    nxt_addr       = addr_ff;
    nxt_addr_valid = addr_valid_ff;
    case (state_ff)
      pbp_pkg::PBP_STRAP: begin
        // Pin released as input; wait for flash load, strap settled by then
        nxt_idx1_oe_b = pbp_pkg::OE_RELEASE;
        if (flash_loaded_i) begin
          nxt_addr       = pick_addr(strap_s2_ff);
          nxt_addr_valid = 1'b1;
          nxt_state      = pbp_pkg::PBP_PARKED;
          nxt_oe_b       = pbp_pkg::OE_DRIVE;
          nxt_idx1_oe_b  = pbp_pkg::OE_DRIVE;
          nxt_pins       = '0;
        end
      end
      pbp_pkg::PBP_PARKED: begin
        nxt_pins = '0;
        if (out_enable_i) begin
          nxt_state = pbp_pkg::PBP_ACTIVE;
        end
      end
      pbp_pkg::PBP_ACTIVE: begin
        if (!out_enable_i) begin
          nxt_state = pbp_pkg::PBP_PARKED;
          nxt_pins  = '0;
        end else begin
          nxt_pins.swap = advance_i;
          if (advance_i) begin
            nxt_pins.index = pins_ff.index + pbp_pkg::IDX_STEP;
          end
        end
      end
      default: begin
        nxt_state = pbp_pkg::PBP_STRAP;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      strap_s1_ff   <= 1'b0;
      strap_s2_ff   <= 1'b0;
      state_ff      <= pbp_pkg::PBP_STRAP;
      pins_ff       <= '0;
      oe_b_ff       <= pbp_pkg::OE_RELEASE;
      idx1_oe_b_ff  <= pbp_pkg::OE_RELEASE;
      addr_ff       <= pbp_pkg::SLV_ADDR_LOW;
      addr_valid_ff <= 1'b0;
    end else begin
      strap_s1_ff   <= nxt_strap_s1;
      strap_s2_ff   <= nxt_strap_s2;
      state_ff      <= nxt_state;
      pins_ff       <= nxt_pins;
      oe_b_ff       <= nxt_oe_b;
      idx1_oe_b_ff  <= nxt_idx1_oe_b;
      addr_ff       <= nxt_addr;
      addr_valid_ff <= nxt_addr_valid;
    end
  end

  // Bit order fixed for the far end's read pointer inputs
  assign buffer_index_bit0_o      = pins_ff.index[0];
  assign buffer_index_bit1_o      = pins_ff.index[1];
  assign buffer_swap_o            = pins_ff.swap;
  assign buffer_index_bit0_oe_b_o = oe_b_ff;
  assign buffer_swap_oe_b_o       = oe_b_ff;
  assign buffer_index_bit1_oe_b_o = idx1_oe_b_ff;
  assign slave_addr_o             = addr_ff;
  assign addr_valid_o             = addr_valid_ff;

endmodule : pbp_port

// ### pbp_port_asserts.sv
// Checker for the pattern buffer pointer port
`timescale 1ns/10ps
module pbp_port_asserts (input logic sys_clk_i, rst_b_i, flash_loaded_i, out_enable_i,
  advance_i, buffer_index_bit1_i, buffer_index_bit0_o, buffer_index_bit1_o, addr_valid_o,
  buffer_index_bit1_oe_b_o, buffer_index_bit0_oe_b_o, buffer_swap_o, buffer_swap_oe_b_o,
  input logic [6:0] slave_addr_o);
  wire [1:0] ix = {buffer_index_bit1_o, buffer_index_bit0_o};
  wire [2:0] oe = {buffer_index_bit1_oe_b_o, buffer_index_bit0_oe_b_o, buffer_swap_oe_b_o};
  wire       sw = buffer_swap_o;
  wire       av = addr_valid_o;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_STEP: assert property (sw |-> ix == $past(ix) + 2'h1) else $error("step");
  AST_SWAP: assert property (sw |-> $past(advance_i)) else $error("swap");
  AST_GATE: assert property (sw |-> $past(out_enable_i, 2)) else $error("gate");
  AST_HIZ: assert property (!av |-> oe == 3'h7) else $error("hiz");
  AST_DRV: assert property (av |-> oe == 3'h0) else $error("drv");
  AST_PARK: assert property (av && !$past(out_enable_i) |-> !ix && !sw) else $error("park");
  AST_VAL: assert property ($rose(av) |-> $past(flash_loaded_i)) else $error("val");
  AST_ADDR: assert property (!av |-> slave_addr_o == 7'h1B) else $error("addr");
  AST_ADDR_SEL: assert property ($rose(av) |-> slave_addr_o == ($past(buffer_index_bit1_i, 3) ? 7'h1D : 7'h1B)) else $error("addr sel");
  AST_ADDR_HOLD: assert property (av && $past(av) |-> $stable(slave_addr_o)) else $error("addr hold");
endmodule : pbp_port_asserts
bind pbp_port pbp_port_asserts pbp_port_asserts_i (.*);

// ### pbp_fpga_model.sv
// Far-side buffer manager model
`timescale 1ns/10ps
module pbp_fpga_model (input logic sys_clk_i, fpga_swap_sequence_in,
  input logic [1:0] fpga_read_pointer_in, output logic [1:0] cur_buf);
  always_ff @(posedge sys_clk_i)
    if (fpga_swap_sequence_in) cur_buf <= fpga_read_pointer_in;
endmodule : pbp_fpga_model

// ### tb_pbp_port.sv
// Self-checking bench for the pattern buffer pointer port
`timescale 1ns/10ps
module tb_pbp_port;
  logic sys_clk_i = 0, rst_b_i, flash_loaded_i, out_enable_i, advance_i, strap;
  logic buffer_index_bit0_o, buffer_index_bit1_o, buffer_swap_o, addr_valid_o;
  logic buffer_index_bit0_oe_b_o, buffer_index_bit1_oe_b_o, buffer_swap_oe_b_o;
  logic [6:0] slave_addr_o;
  logic [1:0] cur_buf;
  int miscompares = 0, tests_run = 0;
  // Released pins sit on pull-downs; the shared one on its strap
  wire buffer_index_bit1_i = buffer_index_bit1_oe_b_o ? strap : buffer_index_bit1_o;
  wire fpga_swap_sequence_in = !buffer_swap_oe_b_o && buffer_swap_o;
  wire [1:0] fpga_read_pointer_in = {buffer_index_bit1_i,
    !buffer_index_bit0_oe_b_o && buffer_index_bit0_o};
  wire [2:0] pins = {fpga_swap_sequence_in, fpga_read_pointer_in};
  pbp_port pbp_port_i (.*);
  pbp_fpga_model pbp_fpga_model_i (.*);
  initial forever #5 sys_clk_i = ~sys_clk_i;
  task chk(input logic [6:0] g, e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task final_report;
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task boot(input logic s);
    {rst_b_i, flash_loaded_i, out_enable_i, advance_i, strap} = {4'h0, s};
    repeat (4) @(negedge sys_clk_i);
    rst_b_i = 1;
    repeat (3) @(negedge sys_clk_i);
    chk(pins, {5'h0, s, 1'b0});
    flash_loaded_i = 1;
    for (int k = 0; k < 8 && addr_valid_o !== 1'b1; k++) @(negedge sys_clk_i);
    chk(addr_valid_o, 7'h1);
    if (miscompares > 0) final_report();
    chk(slave_addr_o, s ? 7'h1D : 7'h1B);
    chk(pins, 7'h0);
  endtask : boot
  task run;
    advance_i = 1;
    @(negedge sys_clk_i);
    chk(pins, 7'h0);
    {out_enable_i, advance_i} = 2'h2;
    repeat (2) @(negedge sys_clk_i);
    // Back to back advances run past the wrap
    for (int k = 1; k < 6; k++) begin
      advance_i = 1;
      @(negedge sys_clk_i);
      chk(pins, {5'h1, 2'(k)});
    end
    advance_i = 0;
    @(negedge sys_clk_i);
    chk({pins, cur_buf}, 7'h5);
    {out_enable_i, advance_i} = 2'h1;
    repeat (2) @(negedge sys_clk_i);
    chk(pins, 7'h0);
    advance_i = 0;
  endtask : run
  initial begin
    boot(0);
    run();
    boot(1);
    run();
    final_report();
  end
endmodule : tb_pbp_port
